// ==== verilog/gpiop_pkg.sv ====
// Package for the general-purpose I/O port: register map, field codes and reset values.
// Assumes a 32-bit AXI4-Lite register bus and one port of up to sixteen pins.
package gpiop_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MODE  = 8'h00;
    localparam logic [7:0] OFS_OTYPE = 8'h04;
    localparam logic [7:0] OFS_SPEED = 8'h08;
    localparam logic [7:0] OFS_PULL  = 8'h0C;
    localparam logic [7:0] OFS_ISTAT = 8'h10;
    localparam logic [7:0] OFS_OVAL  = 8'h14;
    localparam logic [7:0] OFS_SETCL = 8'h18;
    localparam logic [7:0] OFS_FRZ   = 8'h1C;
    localparam logic [7:0] OFS_AFS0  = 8'h20;
    localparam logic [7:0] OFS_AFS1  = 8'h24;
    localparam logic [7:0] OFS_CLR   = 8'h28;
    localparam logic [7:0] OFS_TGL   = 8'h2C;
    localparam logic [7:0] OFS_COMP  = 8'h30;

    // ----------------------------------------------------------------
    // Field codes and positions
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_IN  = 2'h0;
    localparam logic [1:0] MODE_OUT = 2'h1;
    localparam logic [1:0] MODE_AF  = 2'h2;
    localparam logic [1:0] MODE_AN  = 2'h3;
    localparam logic [1:0] PULL_UP  = 2'h1;
    localparam logic [1:0] PULL_DN  = 2'h2;
    localparam int         KEY_BIT  = 16;
    localparam int         RDY_BIT  = 8;
    localparam int         CLR_SH   = 16;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    // Debug pins 15/14/13 of the first port: pull-up, pull-down, pull-up.
    localparam logic [31:0] PULL_RST_A  = 32'h6400_0000;
    localparam logic [31:0] PIN_ALL     = 32'h0000_FFFF;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // Freeze key sequence progress.
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_TWO,
        KEY_DONE
    } gpiop_key_t;

endpackage : gpiop_pkg

// ==== verilog/gpiop_pin.sv ====
// One pin's pad control: turns the configuration of a pin into pad drive and enables.
// Purely combinational; the port module registers every result.
module gpiop_pin
    import gpiop_pkg::*;
(
    // Configuration
    input  wire logic [1:0] i_mode,
    input  wire logic       i_otype,
    input  wire logic [1:0] i_pull,
    input  wire logic       i_oval,
    // Peripheral and additional-function drive
    input  wire logic       i_af_out,
    input  wire logic       i_af_oe,
    input  wire logic       i_add_en,
    input  wire logic       i_add_out,
    input  wire logic       i_add_oe,
    // Pad controls
    output logic            o_oe,
    output logic            o_out,
    output logic            o_pu,
    output logic            o_pd,
    output logic            o_st,
    output logic            o_an,
    output logic            o_ext_irq_event_unit
);

    logic drv;
    logic val;

    // Data source and drive request depend on the mode.
    always_comb begin
        drv = 1'b0;
        val = 1'b0;
        case (i_mode)
            MODE_OUT: begin
                drv = 1'b1;
                val = i_oval;
            end
            MODE_AF: begin
                drv = i_af_oe;
                val = i_af_out;
            end
            default: begin
                drv = 1'b0;
                val = 1'b0;
            end
        endcase
        // Open drain only pulls low; a one releases the pad.
        o_oe   = drv & (i_otype ? ~val : 1'b1);
        o_out  = i_otype ? 1'b0 : val;
        o_pu   = (i_mode != MODE_AN) && (i_pull == PULL_UP);
        o_pd   = (i_mode != MODE_AN) && (i_pull == PULL_DN);
        o_st   = (i_mode != MODE_AN);
        o_an   = (i_mode == MODE_AN);
        o_ext_irq_event_unit = (i_mode == MODE_IN);
        // An enabled additional function owns the pad outright.
        if (i_add_en) begin
            o_oe   = i_add_oe;
            o_out  = i_add_out;
            o_pu   = 1'b0;
            o_pd   = 1'b0;
            o_st   = 1'b1;
            o_an   = 1'b0;
            o_ext_irq_event_unit = 1'b0;
        end
    end

endmodule : gpiop_pin

// ==== verilog/gpiop_port.sv ====
// One general-purpose I/O port with an AXI4-Lite register slave and registered pad controls.
// Assumes the pads resolve level from O_PAD_OE/O_PAD_OUT and that pad inputs are asynchronous.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
module gpiop_port
    import gpiop_pkg::*;
#(
    parameter int          N        = 16,
    parameter logic [15:0] PIN_MASK = 16'hFFFF,
    parameter logic [31:0] PULL_RST = PULL_RST_A
) (
    // Clock and reset
    input  wire logic           I_CLK,
    input  wire logic           I_RESETN,
    // AXI4-Lite write channels
    input  wire logic [7:0]     I_AWADDR,
    input  wire logic           I_AWVALID,
    output logic                O_AWREADY,
    input  wire logic [31:0]    I_WDATA,
    input  wire logic [3:0]     I_WSTRB,
    input  wire logic           I_WVALID,
    output logic                O_WREADY,
    output logic [1:0]          O_BRESP,
    output logic                O_BVALID,
    input  wire logic           I_BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]     I_ARADDR,
    input  wire logic           I_ARVALID,
    output logic                O_ARREADY,
    output logic [31:0]         O_RDATA,
    output logic [1:0]          O_RRESP,
    output logic                O_RVALID,
    input  wire logic           I_RREADY,
    // Pads
    input  wire logic [N-1:0]   I_PAD_IN,
    output logic [N-1:0]        O_PAD_OUT,
    output logic [N-1:0]        O_PAD_OE,
    output logic [N-1:0]        O_PULL_UP,
    output logic [N-1:0]        O_PULL_DN,
    output logic [N-1:0]        O_SCHMITT_EN,
    output logic [N-1:0]        O_ANALOG_EN,
    // Peripherals, additional functions and interrupt lines
    input  wire logic [N-1:0]   I_AF_OUT,
    input  wire logic [N-1:0]   I_AF_OE,
    output logic [4*N-1:0]      O_AF_SEL,
    output logic [N-1:0]        O_AF_IN,
    input  wire logic [N-1:0]   I_ADD_EN,
    input  wire logic [N-1:0]   I_ADD_OUT,
    input  wire logic [N-1:0]   I_ADD_OE,
    output logic [N-1:0]        O_EXT_IRQ_EVENT_UNIT_IN,
    // Compensation cell
    input  wire logic           I_COMP_READY,
    output logic                O_COMP_EN
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2*N-1:0] mode;
        logic [N-1:0]   otype;
        logic [2*N-1:0] speed;
        logic [2*N-1:0] pull;
        logic [N-1:0]   oval;
        logic [4*N-1:0] afsel;
        logic [N-1:0]   frz;
        logic [N-1:0]   key_pins;
        gpiop_key_t     key;
        logic           comp_en;
        logic           comp_s1;
        logic           comp_s2;
        logic [N-1:0]   pad_s1;
        logic [N-1:0]   pad_s2;
        logic [N-1:0]   istat;
        logic           aw_held;
        logic           w_held;
        logic [7:0]     waddr;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic [N-1:0]   pad_out;
        logic [N-1:0]   pad_oe;
        logic [N-1:0]   pu;
        logic [N-1:0]   pd;
        logic [N-1:0]   st;
        logic [N-1:0]   an;
        logic [N-1:0]   ext_irq_event_unit;
    } gpiop_state_t;

    localparam logic [N-1:0] PM = PIN_MASK[N-1:0];

    // Pins come up as floating inputs, debug pulls aside, buses idle and ready.
    localparam gpiop_state_t S_RESET = '{
        pull:    PULL_RST[2*N-1:0],
        key:     KEY_IDLE,
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        st:      PM,
        default: '0
    };

    gpiop_state_t s_reg;
    gpiop_state_t s_next;

    // Per-pin combinational pad controls.
    logic [N-1:0] p_oe;
    logic [N-1:0] p_out;
    logic [N-1:0] p_pu;
    logic [N-1:0] p_pd;
    logic [N-1:0] p_st;
    logic [N-1:0] p_an;
    logic [N-1:0] p_ext_irq_event_unit;

    // ----------------------------------------------------------------
    // Pin instances
    // ----------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_pin
        gpiop_pin u_pin (
            .i_mode    (s_reg.mode[2*g +: 2]),
            .i_otype   (s_reg.otype[g]),
            .i_pull    (s_reg.pull[2*g +: 2]),
            .i_oval    (s_reg.oval[g]),
            .i_af_out  (I_AF_OUT[g]),
            .i_af_oe   (I_AF_OE[g]),
            .i_add_en  (I_ADD_EN[g]),
            .i_add_out (I_ADD_OUT[g]),
            .i_add_oe  (I_ADD_OE[g]),
            .o_oe      (p_oe[g]),
            .o_out     (p_out[g]),
            .o_pu      (p_pu[g]),
            .o_pd      (p_pd[g]),
            .o_st      (p_st[g]),
            .o_an      (p_an[g]),
            .o_ext_irq_event_unit    (p_ext_irq_event_unit[g])
        );
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Widen a per-pin mask to fields of w bits each.
    function automatic logic [31:0] spread(input logic [N-1:0] m, input int w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < N; i++) begin
            if (m[i] && (i * w < 32)) begin
                for (int j = 0; j < w; j++) begin
                    r[i * w + j] = 1'b1;
                end
            end
        end
        return r;
    endfunction : spread

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] wd;
        logic [31:0] wm;
        logic [N-1:0] open;
        logic [N-1:0] setv;
        logic [N-1:0] clrv;
        logic [N-1:0] ov;
        logic         hit;
        wd     = '0;
        wm     = '0;
        open   = '0;
        setv   = '0;
        clrv   = '0;
        ov     = '0;
        hit    = 1'b0;
        s_next = s_reg;

        // Pad inputs cross into the clock domain through two flops.
        s_next.pad_s1  = I_PAD_IN;
        s_next.pad_s2  = s_reg.pad_s1;
        s_next.istat   = s_reg.pad_s2 & ~p_an & PM;
        s_next.comp_s1 = I_COMP_READY;
        s_next.comp_s2 = s_reg.comp_s1;

        // Registered pad controls; absent pins stay dead.
        s_next.pad_out = p_out & PM;
        s_next.pad_oe  = p_oe & PM;
        s_next.pu      = p_pu & PM;
        s_next.pd      = p_pd & PM;
        s_next.st      = p_st & PM;
        s_next.an      = p_an & PM;
        s_next.ext_irq_event_unit    = p_ext_irq_event_unit & PM;

        // Write address and data are taken in either order.
        if (I_AWVALID && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.waddr   = I_AWADDR;
        end
        if (I_WVALID && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata  = I_WDATA;
            s_next.wstrb  = I_WSTRB;
        end
        if (s_reg.bvalid && I_BREADY) begin
            s_next.bvalid = 1'b0;
        end

        // A complete write acts once both halves are held.
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            wd = s_reg.wdata;
            wm = merge(ZERO_WORD, PIN_ALL | ~PIN_ALL, s_reg.wstrb);
            open = ~s_reg.frz & PM;
            hit  = 1'b1;
            ov   = s_reg.oval;
            case (s_reg.waddr)
                OFS_MODE: begin
                    s_next.mode = merge(s_reg.mode, wd, s_reg.wstrb & 4'hF)
                                & spread(open, 2) | s_reg.mode & ~spread(open, 2);
                end
                OFS_OTYPE: begin
                    s_next.otype = (wd[N-1:0] & wm[N-1:0] & open)
                                 | (s_reg.otype & ~(wm[N-1:0] & open));
                end
                OFS_SPEED: begin
                    s_next.speed = merge(s_reg.speed, wd, s_reg.wstrb)
                                 & spread(open, 2) | s_reg.speed & ~spread(open, 2);
                end
                OFS_PULL: begin
                    s_next.pull = merge(s_reg.pull, wd, s_reg.wstrb)
                                & spread(open, 2) | s_reg.pull & ~spread(open, 2);
                end
                OFS_ISTAT: begin
                    hit = 1'b1;
                end
                OFS_OVAL: begin
                    ov = (wd[N-1:0] & wm[N-1:0]) | (s_reg.oval & ~wm[N-1:0]);
                end
                OFS_SETCL: begin
                    wd   = wd & wm;
                    setv = wd[N-1:0];
                    clrv = wd[CLR_SH +: N];
                    ov   = (s_reg.oval & ~clrv) | setv;
                end
                OFS_CLR: begin
                    wd = wd & wm;
                    ov = s_reg.oval & ~wd[N-1:0];
                end
                OFS_TGL: begin
                    wd = wd & wm;
                    ov = s_reg.oval ^ wd[N-1:0];
                end
                OFS_AFS0: begin
                    s_next.afsel[31:0] = merge(s_reg.afsel[31:0], wd, s_reg.wstrb)
                                       & spread(open, 4)
                                       | s_reg.afsel[31:0] & ~spread(open, 4);
                end
                OFS_AFS1: begin
                    s_next.afsel[63:32] = merge(s_reg.afsel[63:32], wd, s_reg.wstrb)
                                        & spread(open >> 8, 4)
                                        | s_reg.afsel[63:32] & ~spread(open >> 8, 4);
                end
                OFS_FRZ: begin
                    // Key one, key zero, key one with the same pins arms the freeze.
                    case (s_reg.key)
                        KEY_IDLE: begin
                            s_next.key      = wd[KEY_BIT] ? KEY_ONE : KEY_IDLE;
                            s_next.key_pins = wd[N-1:0] & PM;
                        end
                        KEY_ONE: begin
                            s_next.key = (!wd[KEY_BIT] && (wd[N-1:0] & PM) == s_reg.key_pins)
                                       ? KEY_TWO : KEY_IDLE;
                        end
                        KEY_TWO: begin
                            if (wd[KEY_BIT] && (wd[N-1:0] & PM) == s_reg.key_pins) begin
                                s_next.key = KEY_DONE;
                                s_next.frz = s_reg.key_pins;
                            end else begin
                                s_next.key = KEY_IDLE;
                            end
                        end
                        default: begin
                            s_next.key = KEY_DONE;                    // Held until reset.
                        end
                    endcase
                end
                OFS_COMP: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.comp_en = wd[0];
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            s_next.oval    = ov & PM;
            s_next.mode    = s_next.mode & spread(PM, 2);
            s_next.pull    = s_next.pull & spread(PM, 2);
            s_next.speed   = s_next.speed & spread(PM, 2);
            s_next.otype   = s_next.otype & PM;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = hit ? RESP_OK : RESP_ERR;
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
        end
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready  = !s_next.w_held && !s_next.bvalid;

        // Read: data one cycle after the address is taken.
        if (s_reg.rvalid && I_RREADY) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end
        if (I_ARVALID && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rresp   = RESP_OK;
            s_next.rdata   = '0;
            case (I_ARADDR)
                OFS_MODE:  s_next.rdata = 32'(s_reg.mode);
                OFS_OTYPE: s_next.rdata = 32'(s_reg.otype);
                OFS_SPEED: s_next.rdata = 32'(s_reg.speed);
                OFS_PULL:  s_next.rdata = 32'(s_reg.pull);
                OFS_ISTAT: s_next.rdata = 32'(s_reg.istat);
                OFS_OVAL:  s_next.rdata = 32'(s_reg.oval);
                OFS_SETCL: s_next.rdata = ZERO_WORD;
                OFS_CLR:   s_next.rdata = ZERO_WORD;
                OFS_TGL:   s_next.rdata = ZERO_WORD;
                OFS_AFS0:  s_next.rdata = s_reg.afsel[31:0];
                OFS_AFS1:  s_next.rdata = s_reg.afsel[63:32];
                OFS_FRZ: begin
                    s_next.rdata = 32'(s_reg.frz);
                    s_next.rdata[KEY_BIT] = (s_reg.key == KEY_DONE);
                end
                OFS_COMP: begin
                    s_next.rdata[0]       = s_reg.comp_en;
                    s_next.rdata[RDY_BIT] = s_reg.comp_en & s_reg.comp_s2;
                end
                default: begin
                    s_next.rresp = RESP_ERR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset to a constant; debug pulls come from parameters.
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign O_AWREADY    = s_reg.awready;
    assign O_WREADY     = s_reg.wready;
    assign O_BVALID     = s_reg.bvalid;
    assign O_BRESP      = s_reg.bresp;
    assign O_ARREADY    = s_reg.arready;
    assign O_RVALID     = s_reg.rvalid;
    assign O_RDATA      = s_reg.rdata;
    assign O_RRESP      = s_reg.rresp;
    assign O_PAD_OUT    = s_reg.pad_out;
    assign O_PAD_OE     = s_reg.pad_oe;
    assign O_PULL_UP    = s_reg.pu;
    assign O_PULL_DN    = s_reg.pd;
    assign O_SCHMITT_EN = s_reg.st;
    assign O_ANALOG_EN  = s_reg.an;
    // Alternate-function select follows its register in every pin mode; the input follows input status, which reads zero on analog pins.
    assign O_AF_SEL     = s_reg.afsel;
    assign O_AF_IN      = s_reg.istat;
    assign O_EXT_IRQ_EVENT_UNIT_IN    = s_reg.ext_irq_event_unit;
    assign O_COMP_EN    = s_reg.comp_en;

endmodule : gpiop_port

// ==== verif/gpiop_port_sva.sv ====
// Checker for gpiop_port: pad control and register bus handshake relations.
// Assumes it is bound to gpiop_port and sees that module's ports only.
module gpiop_port_sva #(parameter int N = 16) (
    input wire logic         I_CLK, I_RESETN, O_AWREADY, O_BVALID, I_BREADY,
    input wire logic         O_ARREADY, O_RVALID, I_RREADY,
    input wire logic [N-1:0] O_PAD_OE, O_PULL_UP, O_PULL_DN, O_SCHMITT_EN, O_ANALOG_EN, O_EXT_IRQ_EVENT_UNIT_IN
);
    // One clock domain, so the clock and the reset are given once here.
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    property p_an_pull; (O_ANALOG_EN & (O_PULL_UP | O_PULL_DN)) == '0; endproperty
    a_an_pull: assert property (p_an_pull) else $error("pull on analog pin");
    property p_an_drv; (O_ANALOG_EN & (O_PAD_OE | O_SCHMITT_EN)) == '0; endproperty
    a_an_drv: assert property (p_an_drv) else $error("analog pin driven");
    property p_irq; (O_EXT_IRQ_EVENT_UNIT_IN & (O_PAD_OE | O_ANALOG_EN | ~O_SCHMITT_EN)) == '0; endproperty
    a_irq: assert property (p_irq) else $error("line fed outside input mode");
    property p_rst; $rose(I_RESETN) |-> (O_PAD_OE | O_ANALOG_EN) == '0; endproperty
    a_rst: assert property (p_rst) else $error("pin active after reset");
    property p_bdone; O_BVALID && I_BREADY |=> !O_BVALID; endproperty
    a_bdone: assert property (p_bdone) else $error("write answer repeated");
    property p_rdone; O_RVALID && I_RREADY |=> !O_RVALID; endproperty
    a_rdone: assert property (p_rdone) else $error("read answer repeated");
    property p_awblk; O_BVALID |-> !O_AWREADY; endproperty
    a_awblk: assert property (p_awblk) else $error("address taken while answering");
    property p_arblk; O_RVALID |-> !O_ARREADY; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while answering");
    // Main scenarios: a write answer, an analog pin, a driven pad.
    c_wr: cover property (O_BVALID && I_BREADY);
    c_an: cover property (|O_ANALOG_EN);
    c_oe: cover property (|O_PAD_OE);
endmodule : gpiop_port_sva

bind gpiop_port gpiop_port_sva #(.N(N)) u_sva (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_ARREADY(O_ARREADY),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_PAD_OE(O_PAD_OE), .O_PULL_UP(O_PULL_UP),
    .O_PULL_DN(O_PULL_DN), .O_SCHMITT_EN(O_SCHMITT_EN), .O_ANALOG_EN(O_ANALOG_EN),
    .O_EXT_IRQ_EVENT_UNIT_IN(O_EXT_IRQ_EVENT_UNIT_IN));

// ==== verif/gpiop_pads.sv ====
// Pad model: resolves each pad level from drive, weak pulls and an undriven pattern.
// Assumes the port's pad controls are registered and change just after the clock edge.
module gpiop_pads #(parameter int N = 16) (
    input  wire logic         i_clk,
    input  wire logic [N-1:0] i_oe, i_out, i_pu, i_pd,
    output logic [N-1:0]      o_level
);
    logic [N-1:0] flip_reg = '0;
    // A floating pad flips every cycle, so it never passes for a held level.
    always_ff @(posedge i_clk) flip_reg <= ~flip_reg;
    assign o_level = (i_oe & i_out) | (~i_oe & (i_pu | (~i_pd & flip_reg)));
endmodule : gpiop_pads

// ==== verif/gpiop_port_test.sv ====
// Bench for gpiop_port: AXI4-Lite register traffic checked through the pad model.
// Assumes the checker binds itself; the ready lines of the answers stay high.
module gpiop_port_test
    import gpiop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 1, arv = 0, rr = 1, crdy = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [15:0] afo = 0, afoe = 0, ade = 0, r, m;
    logic [33:0] expq[$], bq[$];
    wire awr, wrdy, bv, arr, rv, cen;
    wire [1:0] rresp, bresp;
    wire [31:0] rdata;
    wire [63:0] afsel;
    wire [15:0] pin, pout, poe, pu, pd, an, afin;
    int errors = 0, n_tests = 0;
    gpiop_port u_dut (.I_CLK(clk), .I_RESETN(rstn), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy),
        .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv),
        .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
        .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE(poe), .O_PULL_UP(pu), .O_PULL_DN(pd),
        .O_SCHMITT_EN(), .O_ANALOG_EN(an), .I_AF_OUT(afo), .I_AF_OE(afoe), .O_AF_SEL(afsel),
        .O_AF_IN(afin), .I_ADD_EN(ade), .I_ADD_OUT(afo), .I_ADD_OE(afoe), .O_EXT_IRQ_EVENT_UNIT_IN(),
        .I_COMP_READY(crdy), .O_COMP_EN(cen));
    gpiop_pads u_pads (.i_clk(clk), .i_oe(poe), .i_out(pout), .i_pu(pu), .i_pd(pd), .o_level(pin));
    // Free-running 250 MHz clock.
    initial forever #2 clk = ~clk;
    task automatic wrap_up;
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Write; then waits three sync edges and one more so pad effects reach input status.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
        logic ad, dd;
        bq.push_back({e, 32'h0});
        {ad, dd} = 2'b00;
        {awa, wd, awv, wv} <= {a, d, 2'b11};
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            {ad, dd} = {ad | awr, dd | wrdy};
        end
        do @(posedge clk); while (!bv);
        repeat (4) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        {ara, arv} <= {a, 1'b1};
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
    endtask : rd
    // Each read answer is matched against the oldest expectation.
    always @(posedge clk) begin
        if (rv) cmp({rresp, rdata}, expq.pop_front());
        if (bv) cmp({bresp, 32'h0}, bq.pop_front());
    end
    // Cuts a hang short well beyond the few hundred cycles the run needs.
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h718a_91c9));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(OFS_MODE, 34'h0);
        rd(OFS_PULL, {RESP_OK, PULL_RST_A});
        rd(8'h40, {RESP_ERR, ZERO_WORD});
        wr(8'h40, ZERO_WORD, RESP_ERR);
        wr(OFS_MODE, 32'h5555_5555);
        wr(OFS_PULL, 32'hAAAA_AAAA);
        for (int k = 0; k < 5; k++) begin
            m = 16'($urandom);
            wr(k == 0 ? OFS_OVAL : k < 3 ? OFS_SETCL : k == 3 ? OFS_CLR : OFS_TGL,
               k == 2 ? {m, 16'h0} : {16'h0, m});
            r = k == 0 ? m : k == 1 ? r | m : k == 4 ? r ^ m : r & ~m;
            rd(OFS_OVAL, {RESP_OK, 16'h0, r});
            rd(OFS_ISTAT, {RESP_OK, 16'h0, r});
        end
        wr(OFS_OTYPE, 32'h0000_FFFF);
        rd(OFS_ISTAT, 34'h0);
        wr(OFS_PULL, 32'h5555_5555);
        rd(OFS_ISTAT, {RESP_OK, 16'h0, r});
        {afo, afoe} <= {16'($urandom), 16'($urandom)};
        wr(OFS_MODE, 32'hAAAA_AAAA);
        rd(OFS_ISTAT, {RESP_OK, 16'h0, ~(afoe & ~afo)});
        cmp({18'h0, afin}, {18'h0, ~(afoe & ~afo)});
        rd(OFS_OVAL, {RESP_OK, 16'h0, r});
        wr(OFS_AFS1, {m, r});
        rd(OFS_AFS1, {RESP_OK, m, r});
        cmp({2'h0, afsel[63:32]}, {2'h0, m, r});
        wr(OFS_MODE, 32'hFFFF_FFFF);
        rd(OFS_ISTAT, 34'h0);
        {crdy, ade} <= {1'b1, afoe};
        wr(OFS_COMP, 32'h0000_0001);
        rd(OFS_COMP, {RESP_OK, 32'h0000_0101});
        cmp(34'(cen), 34'h1);
        rd(OFS_ISTAT, {RESP_OK, 16'h0, afoe & afo});
        for (int k = 0; k < 3; k++) wr(OFS_FRZ, {15'h0, k != 1, 16'h0001});
        rd(OFS_FRZ, {RESP_OK, 32'h0001_0001});
        wr(OFS_MODE, ZERO_WORD);
        rd(OFS_MODE, {RESP_OK, 32'h0000_0003});
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(OFS_MODE, 34'h0);
        wrap_up();
    end
endmodule : gpiop_port_test
